//--- design/adc_sel_pkg.sv
// Constants shared by the converter selection and result control logic.
// Assumes a single core clock domain at 40 MHz.
`default_nettype none
package adc_sel_pkg;
   localparam int RESULT_W = 10;
   localparam int CHAN_W = 5;
   localparam int REF_W = 2;
   localparam logic [9:0] FULL_SCALE = 10'h3FF;
   localparam logic [9:0] ZERO_CODE = 10'h000;
   localparam logic [7:0] NORMAL_CYCLES = 8'h0D;
   localparam logic [7:0] FIRST_CYCLES = 8'h19;
   localparam logic [7:0] PRESCALE_DEFAULT = 8'h04;
   localparam logic [4:0] SEL_RESET = 5'h00;
   localparam logic [1:0] REF_RESET = 2'h0;
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_LAST} conv_state_t;
endpackage
`default_nettype wire

//--- design/adc_sel_ctrl.sv
// Channel and reference selection, conversion sequencing and result coding.
// Assumes CPU-side strobes and the analog sample arrive from core-clock logic;
// trigger and sleep-halt come from the same clock domain.
//
// Behaviour
// R1 - CPU writes go into a freely accessible temporary selection buffer.
// R2 - Buffer copies to active selection while idle; frozen once converting.
// R3 - Copying resumes in last converter cycle before done flag sets.
// R4 - Start bit begins conversion at next converter clock rising edge.
// R5 - Software waits one converter cycle after start to change selection.
// R6 - Under auto-trigger, software changes selection only at safe points.
// R7 - Selection updated at a safe point applies to next conversion.
// R8 - Free-running restart uses old channel; later results use new one.
// R9 - Software selects channel before first start; best waits for done.
// R10 - Single-ended inputs above reference give codes at full scale.
// R11 - Software discards first result after reference switch.
// R12 - Software enables converter idle, single mode, interrupt before sleep.
// R13 - Noise-reduction or idle sleep entry starts conversion after CPU halts.
// R14 - Sleep-started conversion raises completion request, even if awake.
// R15 - After wake the CPU stays active until another sleep instruction.
// R16 - Other sleep modes do not disable converter automatically.
// R17 - Result registers hold result once done flag is high.
// R18 - Single-ended code is unsigned Vin*1024/Vref, 0x000 to 0x3FF.
// R19 - Unipolar differential code is gained difference; negatives give zero.
// R20 - Normal conversion takes 13 cycles; first after enable takes 25.
// R21 - Trigger edge resets prescaler, starts; edges while converting ignored.
// R22 - Unipolar default; bipolar select gives two's complement differential.
// R23 - Reading selection register returns the buffered value last written.
// R24 - Active selection locks on the edge on which conversion starts.
`default_nettype none
module adc_sel_ctrl
   import adc_sel_pkg::*;
#(
   parameter logic [7:0] PRESCALE = PRESCALE_DEFAULT
) (
   input wire logic CORE_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic SEL_WRITE_IN,
   input wire logic [4:0] CHANNEL_SELECT_IN,
   input wire logic [1:0] REFERENCE_SELECT_IN,
   input wire logic CONVERTER_ENABLE_IN,
   input wire logic START_WRITE_IN,
   input wire logic AUTO_TRIGGER_ENABLE_IN,
   input wire logic TRIGGER_IN,
   input wire logic FREE_RUN_IN,
   input wire logic BIPOLAR_SELECT_IN,
   input wire logic DIFFERENTIAL_IN,
   input wire logic SLEEP_HALT_IN,
   input wire logic SLEEP_NOISE_MODE_IN,
   input wire logic DONE_CLEAR_IN,
   input wire logic [10:0] SAMPLE_IN,
   output logic [4:0] CHANNEL_SELECT_OUT,
   output logic [1:0] REFERENCE_SELECT_OUT,
   output logic [4:0] ACTIVE_CHANNEL_OUT,
   output logic [1:0] ACTIVE_REFERENCE_OUT,
   output logic CONVERSION_START_BIT_OUT,
   output logic CONVERSION_DONE_FLAG_OUT,
   output logic [7:0] RESULT_LOW_OUT,
   output logic [7:0] RESULT_HIGH_OUT,
   output logic CONV_TICK_OUT
);
   conv_state_t state, next_state;
   logic [4:0] buf_chan, next_buf_chan, act_chan, next_act_chan;
   logic [1:0] buf_ref, next_buf_ref, act_ref, next_act_ref;
   logic [7:0] presc, next_presc, cnt, next_cnt;
   logic pend, next_pend, first, next_first, done, next_done;
   logic trig_q, next_trig_q, halt_q, next_halt_q;
   logic [9:0] result, next_result;
   logic [9:0] hold, next_hold;
   logic tick, trig_edge, sleep_start, start_req;
   logic [9:0] coded;

   assign tick = (presc == PRESCALE - 8'h01);
   assign trig_edge = TRIGGER_IN & ~trig_q;
   // Only a fresh halt edge in an idle or noise mode starts a sleep conversion.
   assign sleep_start = SLEEP_HALT_IN & ~halt_q
      & SLEEP_NOISE_MODE_IN; // R13 R15 R16

   // Result coding: saturate unipolar negative differences, clip above reference.
   always_comb begin
      coded = SAMPLE_IN[9:0];
      if (SAMPLE_IN[10] && !(DIFFERENTIAL_IN && BIPOLAR_SELECT_IN)) begin
         coded = DIFFERENTIAL_IN ? ZERO_CODE : FULL_SCALE; // R10 R19
      end else if (!SAMPLE_IN[10] && SAMPLE_IN[9] && !DIFFERENTIAL_IN) begin
         coded = SAMPLE_IN[9:0]; // R18
      end else if (DIFFERENTIAL_IN && BIPOLAR_SELECT_IN) begin
         coded = SAMPLE_IN[9:0]; // R22
      end
   end

   always_comb begin
      next_state = state;
      next_buf_chan = buf_chan;
      next_buf_ref = buf_ref;
      next_act_chan = act_chan;
      next_act_ref = act_ref;
      next_presc = tick ? 8'h00 : presc + 8'h01;
      next_cnt = cnt;
      next_pend = pend;
      next_first = first;
      next_done = done;
      next_trig_q = TRIGGER_IN;
      next_halt_q = SLEEP_HALT_IN;
      next_result = result;
      next_hold = hold;
      start_req = pend;
      if (SEL_WRITE_IN) begin
         next_buf_chan = CHANNEL_SELECT_IN; // R1
         next_buf_ref = REFERENCE_SELECT_IN;
      end
      if (state != ST_CONV) begin
         next_act_chan = buf_chan; // R2 R3 R7
         next_act_ref = buf_ref;
      end
      if (DONE_CLEAR_IN) begin
         next_done = 1'b0;
      end
      if (START_WRITE_IN || sleep_start) begin
         next_pend = 1'b1; // R4
      end
      if (AUTO_TRIGGER_ENABLE_IN && trig_edge && state == ST_IDLE
            && !pend) begin
         next_presc = 8'h00; // R21
         next_pend = 1'b1;
      end
      if (!CONVERTER_ENABLE_IN) begin
         next_state = ST_IDLE;
         next_pend = 1'b0;
         next_first = 1'b1;
         next_presc = 8'h00;
      end else if (tick) begin
         case (state)
            ST_IDLE: begin
               if (start_req) begin
                  next_state = ST_CONV;
                  next_act_chan = buf_chan; // R24
                  next_act_ref = buf_ref;
                  next_cnt = (first ? FIRST_CYCLES : NORMAL_CYCLES)
                     - 8'h02; // R20
                  next_first = 1'b0;
               end
            end
            ST_CONV: begin
               // The code is held on every locked edge, because the active
               // selection follows the buffer again in the last cycle.
               next_hold = coded; // R2
               if (cnt == 8'h00) begin
                  next_state = ST_LAST;
               end else begin
                  next_cnt = cnt - 8'h01;
               end
            end
            ST_LAST: begin
               next_done = 1'b1; // R14 R17
               next_result = hold;
               if (FREE_RUN_IN) begin
                  next_state = ST_CONV; // R8
                  next_cnt = NORMAL_CYCLES - 8'h02;
               end else begin
                  next_state = ST_IDLE;
                  next_pend = 1'b0;
               end
            end
            default: next_state = ST_IDLE;
         endcase
      end
      if (buf_ref != next_buf_ref) begin
         next_first = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         state <= ST_IDLE;
         buf_chan <= SEL_RESET;
         buf_ref <= REF_RESET;
         act_chan <= SEL_RESET;
         act_ref <= REF_RESET;
         presc <= 8'h00;
         cnt <= 8'h00;
         pend <= 1'b0;
         first <= 1'b1;
         done <= 1'b0;
         trig_q <= 1'b0;
         halt_q <= 1'b0;
         result <= ZERO_CODE;
         hold <= ZERO_CODE;
      end else begin
         state <= next_state;
         buf_chan <= next_buf_chan;
         buf_ref <= next_buf_ref;
         act_chan <= next_act_chan;
         act_ref <= next_act_ref;
         presc <= next_presc;
         cnt <= next_cnt;
         pend <= next_pend;
         first <= next_first;
         done <= next_done;
         trig_q <= next_trig_q;
         halt_q <= next_halt_q;
         result <= next_result;
         hold <= next_hold;
      end
   end

   assign CHANNEL_SELECT_OUT = buf_chan; // R23
   assign REFERENCE_SELECT_OUT = buf_ref;
   assign ACTIVE_CHANNEL_OUT = act_chan;
   assign ACTIVE_REFERENCE_OUT = act_ref;
   assign CONVERSION_START_BIT_OUT = pend;
   assign CONVERSION_DONE_FLAG_OUT = done;
   assign RESULT_LOW_OUT = result[7:0];
   assign RESULT_HIGH_OUT = {6'h00, result[9:8]};
   assign CONV_TICK_OUT = tick;

   property p_lock;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      (state == ST_CONV) && $past(state == ST_CONV) |-> $stable(act_chan);
   endproperty
   a_lock: assert property (p_lock) else $error("selection moved"); // R2

   property p_buf;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      SEL_WRITE_IN |=> CHANNEL_SELECT_OUT == $past(CHANNEL_SELECT_IN);
   endproperty
   a_buf: assert property (p_buf) else $error("buffer not written"); // R23

   property p_copy;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      state != ST_CONV |=> act_chan == $past(buf_chan);
   endproperty
   a_copy: assert property (p_copy) else $error("idle copy missing"); // R3

   property p_start;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      state == ST_IDLE && pend && tick && CONVERTER_ENABLE_IN
      |=> state == ST_CONV && act_chan == $past(buf_chan);
   endproperty
   a_start: assert property (p_start) else $error("start not taken"); // R24

   property p_done;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      state == ST_LAST && tick && CONVERTER_ENABLE_IN |=> done;
   endproperty
   a_done: assert property (p_done) else $error("done not set"); // R17

   property p_sat;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      SAMPLE_IN[10] && DIFFERENTIAL_IN && !BIPOLAR_SELECT_IN
      |-> coded == ZERO_CODE;
   endproperty
   a_sat: assert property (p_sat) else $error("no saturation"); // R19

   property p_full;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      SAMPLE_IN[10] && !DIFFERENTIAL_IN |-> coded == FULL_SCALE;
   endproperty
   a_full: assert property (p_full) else $error("no clip"); // R10

   property p_sleep;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      sleep_start && CONVERTER_ENABLE_IN |=> pend;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep start lost"); // R13

   c_conv: cover property (@(posedge CORE_CLK_IN) state == ST_LAST ##1 done);
   c_free: cover property (@(posedge CORE_CLK_IN)
      state == ST_LAST && FREE_RUN_IN && tick);
   c_trig: cover property (@(posedge CORE_CLK_IN)
      trig_edge && AUTO_TRIGGER_ENABLE_IN);
   c_sleep: cover property (@(posedge CORE_CLK_IN)
      sleep_start ##1 pend);

   property p_hold;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      state == ST_LAST && tick && CONVERTER_ENABLE_IN
      |=> result == $past(hold);
   endproperty
   a_hold: assert property (p_hold) else $error("result not held"); // R17

   property p_free;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      state == ST_LAST && tick && CONVERTER_ENABLE_IN && FREE_RUN_IN
      |=> state == ST_CONV && pend;
   endproperty
   a_free: assert property (p_free) else $error("no restart"); // R8

   property p_clear;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      DONE_CLEAR_IN && !(state == ST_LAST && tick && CONVERTER_ENABLE_IN)
      |=> !done;
   endproperty
   a_clear: assert property (p_clear) else $error("done stuck"); // R14

   property p_off;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      !CONVERTER_ENABLE_IN |=> state == ST_IDLE && !pend && first;
   endproperty
   a_off: assert property (p_off) else $error("disable not taken"); // R20

   property p_trig;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      AUTO_TRIGGER_ENABLE_IN && trig_edge && state == ST_IDLE && !pend
      && CONVERTER_ENABLE_IN |=> pend && presc == 8'h00;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger lost"); // R21

   property p_ignore;
      @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
      AUTO_TRIGGER_ENABLE_IN && trig_edge && state != ST_IDLE && !tick
      && CONVERTER_ENABLE_IN |=> presc == $past(presc) + 8'h01;
   endproperty
   a_ignore: assert property (p_ignore) else $error("edge taken"); // R21
endmodule
`default_nettype wire

//--- verif/analog_src.sv
// Analog source model: turns the active channel into a converter sample.
// Assumes the control block drives the active channel selection.
`default_nettype none
module analog_src (
   input wire logic [4:0] active_channel_in,
   output logic [10:0] sample_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // Channels 24 to 31 flag out of range: above the reference when single
   // ended, a negative difference when differential.
   assign sample_out = {&active_channel_in[4:3], active_channel_in,
      active_channel_in};
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the selection and result control block.
// Assumes the analog source model feeds the sample input.
`default_nettype none
module tb_top
   import adc_sel_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst_n = 1'b0, sel_wr = 1'b0, en = 1'b0, st_wr = 1'b0;
   logic ate = 1'b0, trig = 1'b0, slp = 1'b0, nmode = 1'b0, clr = 1'b0;
   logic done_q = 1'b0, fr = 1'b0, diff = 1'b0, bip = 1'b0;
   logic [4:0] ch_in = 5'h00;
   logic [1:0] ref_in = 2'h1;
   wire logic [10:0] sample;
   logic [4:0] ch_o, act;
   logic [1:0] rf_o, actr;
   logic sbit, done, tick;
   logic [7:0] rl, rh;
   logic [9:0] exp_q[$];
   int error_cnt = 0, n_checks = 0, seed = 59, r;
   adc_sel_ctrl #(.PRESCALE(8'h03)) u_adc_sel_ctrl (.CORE_CLK_IN(clk),
      .RST_N_IN(rst_n), .SEL_WRITE_IN(sel_wr), .CHANNEL_SELECT_IN(ch_in),
      .REFERENCE_SELECT_IN(ref_in), .CONVERTER_ENABLE_IN(en),
      .START_WRITE_IN(st_wr), .AUTO_TRIGGER_ENABLE_IN(ate),
      .TRIGGER_IN(trig), .FREE_RUN_IN(fr), .BIPOLAR_SELECT_IN(bip),
      .DIFFERENTIAL_IN(diff), .SLEEP_HALT_IN(slp),
      .SLEEP_NOISE_MODE_IN(nmode), .DONE_CLEAR_IN(clr), .SAMPLE_IN(sample),
      .CHANNEL_SELECT_OUT(ch_o), .REFERENCE_SELECT_OUT(rf_o),
      .ACTIVE_CHANNEL_OUT(act), .ACTIVE_REFERENCE_OUT(actr),
      .CONVERSION_START_BIT_OUT(sbit), .CONVERSION_DONE_FLAG_OUT(done),
      .RESULT_LOW_OUT(rl), .RESULT_HIGH_OUT(rh), .CONV_TICK_OUT(tick));
   analog_src u_analog_src (.active_channel_in(act), .sample_out(sample));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic clk_n(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // Each completion is matched against the oldest expected result.
   always @(posedge clk) begin
      done_q <= done;
      if (done === 1'b1 && done_q === 1'b0) begin
         if (exp_q.size() == 0) chk(16'hFFFF, 16'h0000);
         else chk({rh, rl}, {6'h00, exp_q.pop_front()});
      end
   end
   // Kind 0 is a start write, kind 1 a trigger edge, kind 2 a sleep halt.
   task automatic conv(input logic [4:0] c, input int kind, input int cyc);
      int nt, i;
      nt = 0;
      chk({15'h0000, done}, 16'h0000);
      ch_in = c;
      sel_wr = 1'b1;
      clk_n(1);
      sel_wr = 1'b0;
      clk_n(1);
      chk({9'h000, rf_o, ch_o}, {9'h000, ref_in, c});
      chk({9'h000, actr, act}, {9'h000, ref_in, c});
      exp_q.push_back(c[4:3] != 2'b11 || (diff && bip) ? {c, c} :
         (diff ? ZERO_CODE : FULL_SCALE));
      if (kind == 0) st_wr = 1'b1;
      else if (kind == 1) trig = 1'b1;
      else slp = 1'b1;
      clk_n(1);
      st_wr = 1'b0;
      ch_in = c ^ 5'h01;
      if (kind == 0) chk({15'h0000, sbit}, 16'h0001);
      for (i = 0; i < 3000 && done !== 1'b1; i++) begin
         sel_wr = (nt == 4);
         if (kind == 1) trig = (nt != 6);
         if (nt == 8) chk({11'h000, act}, {11'h000, c});
         if (tick === 1'b1) nt++;
         @(posedge clk);
         #2;
      end
      if (done !== 1'b1) begin
         error_cnt++;
         conclude();
      end
      chk({15'h0000, sbit}, 16'h0000);
      chk({11'h000, act}, {11'h000, c ^ 5'h01});
      chk(nt[15:0], cyc[15:0]);
      trig = 1'b0;
      slp = 1'b0;
      clr = 1'b1;
      clk_n(1);
      clr = 1'b0;
   endtask
   // Waits for a completion, then clears the done flag.
   task automatic wait_done();
      int i;
      for (i = 0; i < 3000 && done !== 1'b1; i++) begin
         @(posedge clk);
         #2;
      end
      if (done !== 1'b1) begin
         error_cnt++;
         conclude();
      end
      clr = 1'b1;
      clk_n(1);
      clr = 1'b0;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #2;
      rst_n = 1'b1;
      chk({2'h0, ch_o, act, rf_o, actr}, 16'h0000);
      chk({rh, rl}, 16'h0000);
      en = 1'b1;
      conv(5'h00, 0, FIRST_CYCLES + 1);
      conv(5'h18, 0, NORMAL_CYCLES + 1);
      repeat (3) begin
         r = $random(seed);
         conv(r[4:0], 0, NORMAL_CYCLES + 1);
      end
      ate = 1'b1;
      conv(5'h07, 1, NORMAL_CYCLES + 1);
      ate = 1'b0;
      en = 1'b0;
      clk_n(2);
      en = 1'b1;
      conv(5'h06, 0, FIRST_CYCLES + 1);
      ref_in = 2'h2;
      conv(5'h03, 0, FIRST_CYCLES + 1);
      diff = 1'b1;
      conv(5'h1F, 0, NORMAL_CYCLES + 1);
      bip = 1'b1;
      conv(5'h1C, 0, NORMAL_CYCLES + 1);
      diff = 1'b0;
      bip = 1'b0;
      // Free running: a change after the first completion reaches the third result.
      fr = 1'b1;
      ch_in = 5'h03;
      sel_wr = 1'b1;
      clk_n(1);
      sel_wr = 1'b0;
      exp_q.push_back({5'h03, 5'h03});
      exp_q.push_back({5'h03, 5'h03});
      exp_q.push_back({5'h0C, 5'h0C});
      st_wr = 1'b1;
      clk_n(1);
      st_wr = 1'b0;
      wait_done();
      ch_in = 5'h0C;
      sel_wr = 1'b1;
      clk_n(1);
      sel_wr = 1'b0;
      wait_done();
      chk({15'h0000, sbit}, 16'h0001);
      fr = 1'b0;
      wait_done();
      chk({15'h0000, sbit}, 16'h0000);
      nmode = 1'b1;
      conv(5'h0A, 2, NORMAL_CYCLES + 1);
      nmode = 1'b0;
      slp = 1'b1;
      clk_n(40);
      conv(5'h11, 0, NORMAL_CYCLES + 1);
      clk_n(40);
      conclude();
   end
endmodule
`default_nettype wire
